// ### sim/txpa_regs_assertions.sv
`timescale 1ns/1ps
module txpa_chk (
  input wire              i_ref_clk, i_rst, i_ce, i_wr, i_rd,
  input wire [11:0]       i_addr,
  input wire [7:0]        i_wdata, o_rdata,
  input wire              o_rvalid, i_tx_enable_pin_a, i_tx_enable_pin_b,
  input wire              i_amp_protection_ok, i_amp_tx_fsm_on, i_amp_blanking_fsm_on,
  input wire              i_conv_pll_lock_ev, i_conv_pll_unlock_ev,
  input wire              i_link_pll_lock_ev, i_link_pll_unlock_ev,
  input wire [3:0]        o_dac_powerdown, o_coarse_delay_code,
  input wire              o_ref_powerdown, o_tx_enable_a, o_tx_enable_b, o_amp_enable, o_irq,
  input wire signed [4:0] o_coarse_delay_half
);
  reg [7:0] ie_r, src_r, mk_r;
  wire w = i_ce && i_wr;
  wire [3:0] ev = {i_conv_pll_unlock_ev, i_conv_pll_lock_ev, i_link_pll_unlock_ev,
                   i_link_pll_lock_ev};
  wire [3:0] on = {i_amp_protection_ok, i_amp_tx_fsm_on, i_amp_blanking_fsm_on, src_r[2]};
  wire amp_x = |src_r[6:3] && &(on | ~src_r[6:3]);
  // shadow copies of the irq-enable, source and mask registers that steer the outputs
  always @(posedge i_ref_clk) begin
    ie_r <= i_rst ? 8'h00 : (w && i_addr == 12'h01f) ? i_wdata : ie_r;
    src_r <= i_rst ? 8'h20 : (w && i_addr == 12'h013) ? i_wdata : src_r;
    mk_r <= i_rst ? 8'h00 : (w && i_addr == 12'h012) ? i_wdata : mk_r;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_irq_enabled: assert property (i_ce && |(ev & ie_r[5:2]) |=> o_irq)
    else $error("irq missing");
  chk_irq_masked: assert property (i_ce && !(|(ev & ie_r[5:2])) |=> !o_irq)
    else $error("irq without enabled event");
  chk_amp_source: assert property (i_ce |=> o_amp_enable == $past(amp_x))
    else $error("amp enable wrong");
  chk_delay_map: assert property (o_coarse_delay_half == $signed({1'b0, o_coarse_delay_code}) - 5'sd8)
    else $error("delay half wrong");
  chk_delay_write: assert property (w && i_addr == 12'h014 ##1 i_ce |=> o_coarse_delay_code == $past(i_wdata[3:0], 2))
    else $error("delay code not written");
  chk_pair_b_down: assert property ((mk_r[7] && !o_tx_enable_b)[*2] |-> &o_dac_powerdown[3:2])
    else $error("pair b not down");
  chk_tx_soft: assert property ((src_r[1:0] == 2'b11)[*6] |-> o_tx_enable_a && o_tx_enable_b)
    else $error("soft tx enable ignored");
  chk_read_valid: assert property (i_ce && i_rd |=> o_rvalid)
    else $error("read not answered");
  cover property (o_irq);
  cover property (o_amp_enable);
  cover property (w && i_addr == 12'h014);
endmodule // txpa_chk
bind txpa_regs txpa_chk txpa_chk_inst (.*);

// ### sim/txpa_regs_tb.sv
`timescale 1ns/1ps
module txpa_regs_tb;
  reg clk = 0, rst = 1, wr = 0, rd = 0, pa = 0, pb = 0, pr = 0, tf = 0, bl = 0, ce = 1;
  reg [3:0] ev = 0;
  reg [11:0] ad = 0;
  reg [7:0] wd = 0;
  reg [31:0] s = 32'h6e9b2503;
  integer num_errors = 0, n_checks = 0, i;
  wire [7:0] rdat;
  wire rv, ta, tb, amp, irq, rp;
  wire [3:0] pd, code;
  wire signed [4:0] half;
  txpa_regs txpa_regs_inst (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_wr(wr), .i_rd(rd),
    .i_addr(ad), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .i_tx_enable_pin_a(pa),
    .i_tx_enable_pin_b(pb), .i_amp_protection_ok(pr), .i_amp_tx_fsm_on(tf),
    .i_amp_blanking_fsm_on(bl), .i_conv_pll_lock_ev(ev[2]), .i_conv_pll_unlock_ev(ev[3]),
    .i_link_pll_lock_ev(ev[0]), .i_link_pll_unlock_ev(ev[1]), .o_dac_powerdown(pd),
    .o_ref_powerdown(rp), .o_tx_enable_a(ta), .o_tx_enable_b(tb), .o_amp_enable(amp),
    .o_coarse_delay_code(code), .o_coarse_delay_half(half), .o_irq(irq));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task chk(input [8*5:1] nm, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (e !== g) begin
        num_errors = num_errors + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wt(input [11:0] a, input [7:0] v);
    begin
      @(negedge clk) {wr, ad, wd} = {1'b1, a, v};
      @(negedge clk) wr = 0;
    end
  endtask
  task rt(input [11:0] a, input [7:0] e);
    begin
      @(negedge clk) {rd, ad} = {1'b1, a};
      @(negedge clk) rd = 0;
      chk("rdata", e, rv ? rdat : 8'hxx);
    end
  endtask
  // pins cross a synchroniser, so allow it to settle
  task pdchk(input [3:0] e, input [1:0] t);
    begin
      repeat (8) @(negedge clk);
      chk("pd", {4'h0, e}, {4'h0, pd});
      chk("txen", {6'h0, t}, {6'h0, ta, tb});
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    #20000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    chk("ref", 8'h01, {7'h0, rp});
    rt(12'h011, 8'hf8);
    rt(12'h012, 8'h00);
    rt(12'h013, 8'h20);
    rt(12'h014, 8'h08);
    rt(12'h01f, 8'h00);
    wt(12'h013, 8'hff);
    rt(12'h013, 8'h7f);
    wt(12'h014, 8'hff);
    rt(12'h014, 8'h0f);
    wt(12'h015, 8'hff);
    rt(12'h015, 8'h00);
    $display("register map done");
    for (i = 0; i < 24; i = i + 1) begin
      s = xs(s);
      wt(12'h013, {1'b0, s[6:2], 2'b00});
      @(negedge clk) {pr, tf, bl} = s[10:8];
      @(negedge clk);
      chk("amp", |s[6:3] && &({s[10:8], s[2]} | ~s[6:3]), amp);
    end
    $display("amp sources done");
    for (i = 0; i < 16; i = i + 1) begin
      s = xs(s);
      wt(12'h01f, (i == 0) ? 8'hff : (i == 1) ? 8'h00 : s[7:0]);
      @(negedge clk) ev = 4'h1 << i[1:0];
      @(negedge clk) ev = 0;
      chk("irq", ((i == 0) || (i > 1 && s[2 + i[1:0]])), irq);
    end
    $display("interrupts done");
    wt(12'h011, 8'h00);
    wt(12'h013, 8'h20);
    wt(12'h012, 8'hc0);
    pdchk(4'hf, 2'b00);
    chk("ref", 8'h00, {7'h0, rp});
    pa = 1;
    pdchk(4'hc, 2'b10);
    wt(12'h011, 8'h40);
    pdchk(4'hd, 2'b10);
    wt(12'h013, 8'h23);
    pdchk(4'h1, 2'b11);
    wt(12'h013, 8'h22);
    pdchk(4'hf, 2'b00);
    wt(12'h013, 8'h20);
    pb = 1;
    pdchk(4'h1, 2'b11);
    $display("power-down done");
    for (i = 0; i < 16; i = i + 1) begin
      wt(12'h014, {4'hf, i[3:0]});
      @(negedge clk);
      chk("code", {4'h0, i[3:0]}, {4'h0, code});
      chk("half", {3'h0, i[4:0] - 5'd8}, {3'h0, half});
    end
    $display("delay done");
    ce = 0;
    wt(12'h014, 8'h03);
    @(negedge clk);
    chk("code", 8'h0f, {4'h0, code});
    ce = 1;
    rt(12'h014, 8'h0f);
    $display("clock enable done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    chk("ref", 8'h01, {7'h0, rp});
    rt(12'h014, 8'h08);
    rt(12'h013, 8'h20);
    $display("mid-run reset done");
    conclude;
  end
endmodule // txpa_regs_tb

// ### src/txpa_defs.vh
`ifndef TXPA_DEFS_VH
`define TXPA_DEFS_VH
// register offsets (12-bit address)
`define TXPA_ADDR_PWRDN   12'h011
`define TXPA_ADDR_MASK    12'h012
`define TXPA_ADDR_SRC     12'h013
`define TXPA_ADDR_DLY     12'h014
`define TXPA_ADDR_IRQEN   12'h01f
// reset values
`define TXPA_RST_PWRDN    8'hf8
`define TXPA_RST_MASK     8'h00
`define TXPA_RST_SRC      8'h20
`define TXPA_RST_DLY      8'h08
`define TXPA_RST_IRQEN    8'h00
// writable-bit masks
`define TXPA_WM_SRC       8'h7f
`define TXPA_WM_DLY       8'h0f
// field positions
`define TXPA_BIT_PD_REF   7
`define TXPA_BIT_PD_DAC0  6
`define TXPA_BIT_MASK_B   7
`define TXPA_BIT_MASK_A   6
`define TXPA_BIT_SRC_PROT 6
`define TXPA_BIT_SRC_TXSM 5
`define TXPA_BIT_SRC_BLSM 4
`define TXPA_BIT_SRC_SW   3
`define TXPA_BIT_SW_ON    2
`define TXPA_BIT_TXSW_SEL 1
`define TXPA_BIT_TXSW_VAL 0
`define TXPA_BIT_IRQ_CUL  5
`define TXPA_BIT_IRQ_CL   4
`define TXPA_BIT_IRQ_LUL  3
`define TXPA_BIT_IRQ_LL   2
// coarse delay: code 0 = -4 periods, step 1/2 period; offset in half periods
`define TXPA_DLY_OFS_HALF 5'h08
`endif

// ### src/txpa_regs.v
// Overview of operation
// R1: pair-B mask set and pin B low powers down DACs 2 and 3.
// R2: pair-A mask set and pin A low powers down DACs 0 and 1.
// R3: protection-source bit, reset 0, lets protection block drive amp enable.
// R4: tx-fsm source bit, reset 1, lets transmit state machine drive amp enable.
// R5: blanking source bit, reset 0, lets blanking state machine drive amp enable.
// R6: software source bit makes amp enable follow the software on bit below it.
// R7: software tx select replaces the enable pins with the software value bit.
// R8: four-bit coarse delay resets to 8; 0 minimum, 15 maximum.
// R9: delay spans -4 to +3.5 DAC periods in half-period steps.
// R10: enable bit lets converter PLL unlock raise an interrupt.
// R11: enable bit lets converter PLL lock raise an interrupt.
// R12: enable bit lets link PLL unlock raise an interrupt.
// R13: enable bit lets link PLL lock raise an interrupt.
// R14: an individual DAC power-down bit always powers that DAC down.
// R15: interrupt rises only for events whose enable bit is set.
// R16: with several amp sources selected, all must request on.
`timescale 1ns/1ps
`include "txpa_defs.vh"
module txpa_regs (
  // clock and control
  input  wire              i_ref_clk,
  input  wire              i_rst,
  input  wire              i_ce,
  // register port from serial interface
  input  wire              i_wr,
  input  wire              i_rd,
  input  wire [11:0]       i_addr,
  input  wire [7:0]        i_wdata,
  output reg  [7:0]        o_rdata,
  output reg               o_rvalid,
  // pins (asynchronous)
  input  wire              i_tx_enable_pin_a,
  input  wire              i_tx_enable_pin_b,
  // amp enable sources (same clock)
  input  wire              i_amp_protection_ok,
  input  wire              i_amp_tx_fsm_on,
  input  wire              i_amp_blanking_fsm_on,
  // pll lock events (same clock, one-cycle pulses)
  input  wire              i_conv_pll_lock_ev,
  input  wire              i_conv_pll_unlock_ev,
  input  wire              i_link_pll_lock_ev,
  input  wire              i_link_pll_unlock_ev,
  // outputs
  output reg  [3:0]        o_dac_powerdown,
  output reg               o_ref_powerdown,
  output reg               o_tx_enable_a,
  output reg               o_tx_enable_b,
  output reg               o_amp_enable,
  output reg  [3:0]        o_coarse_delay_code,
  output reg signed [4:0]  o_coarse_delay_half,
  output reg               o_irq
);
  reg [7:0] pwrdn_r;
  reg [7:0] mask_r;
  reg [7:0] src_r;
  reg [7:0] dly_r;
  reg [7:0] irqen_r;
  wire      pin_a_s;
  wire      pin_b_s;

  txpa_sync u_sync_a (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_async   (i_tx_enable_pin_a),
    .o_sync    (pin_a_s)
  );
  txpa_sync u_sync_b (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_async   (i_tx_enable_pin_b),
    .o_sync    (pin_b_s)
  );

  // register read mux
  function [7:0] reg_read;
    input [11:0] a;
    begin
      case (a)
        `TXPA_ADDR_PWRDN: reg_read = pwrdn_r;
        `TXPA_ADDR_MASK:  reg_read = mask_r;
        `TXPA_ADDR_SRC:   reg_read = src_r;
        `TXPA_ADDR_DLY:   reg_read = dly_r;
        `TXPA_ADDR_IRQEN: reg_read = irqen_r;
        default:          reg_read = 8'h00;
      endcase
    end
  endfunction

  // decoded write strobes, already gated by the clock enable
  wire                     wr_en;
  wire                     wr_pwrdn;
  wire                     wr_mask;
  wire                     wr_src;
  wire                     wr_dly;
  wire                     wr_irqen;
  // next values of the registered outputs
  reg                      tx_a_nxt;
  reg                      tx_b_nxt;
  reg  [3:0]               pd_nxt;
  reg                      amp_nxt;
  reg                      any_src;
  reg                      irq_nxt;
  wire [4:0]               dly_half_nxt;

  // true when the request addresses the given register
  function addr_hit;
    input [11:0] a;
    input [11:0] target;
    begin
      addr_hit = (a == target);
    end
  endfunction

  // effective transmit enable: software override or synchronised pin
  function tx_effective;
    input sw_sel;
    input sw_val;
    input pin;
    begin
      tx_effective = sw_sel ? sw_val : pin;
    end
  endfunction

  // a dac is down when its own bit is set or its masked pair is disabled
  function dac_down;
    input own_pd;
    input pair_mask;
    input pair_tx;
    begin
      dac_down = own_pd | (pair_mask & ~pair_tx);
    end
  endfunction

  // a source that is not selected does not veto the amp
  function src_vote;
    input selected;
    input request;
    begin
      src_vote = ~selected | request;
    end
  endfunction

  // an event reaches the interrupt only through its enable bit
  function irq_hit;
    input enable;
    input pulse;
    begin
      irq_hit = enable & pulse;
    end
  endfunction

  assign wr_en    = i_ce & i_wr;
  assign wr_pwrdn = wr_en & addr_hit(i_addr, `TXPA_ADDR_PWRDN);
  assign wr_mask  = wr_en & addr_hit(i_addr, `TXPA_ADDR_MASK);
  assign wr_src   = wr_en & addr_hit(i_addr, `TXPA_ADDR_SRC);
  assign wr_dly   = wr_en & addr_hit(i_addr, `TXPA_ADDR_DLY);
  assign wr_irqen = wr_en & addr_hit(i_addr, `TXPA_ADDR_IRQEN);

  // individual power-down bits: ref, dac0..dac3 in bits 7..3
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwrdn_r <= `TXPA_RST_PWRDN;
    end else if (wr_pwrdn) begin
      pwrdn_r <= i_wdata;
    end
  end

  // pin masks for the two dac pairs
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      mask_r <= `TXPA_RST_MASK;
    end else if (wr_mask) begin
      mask_r <= i_wdata;
    end
  end

  // amp sources and software transmit enable; bit 7 reads zero
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      src_r <= `TXPA_RST_SRC; // see R3 R4 R5
    end else if (wr_src) begin
      src_r <= i_wdata & `TXPA_WM_SRC;
    end
  end

  // coarse delay; upper nibble reads zero
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      dly_r <= `TXPA_RST_DLY; // see R8
    end else if (wr_dly) begin
      dly_r <= i_wdata & `TXPA_WM_DLY; // see R8
    end
  end

  // pll interrupt enables
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      irqen_r <= `TXPA_RST_IRQEN;
    end else if (wr_irqen) begin
      irqen_r <= i_wdata;
    end
  end

  // next values of the control outputs
  always @* begin
    tx_a_nxt  = tx_effective(src_r[`TXPA_BIT_TXSW_SEL],
                             src_r[`TXPA_BIT_TXSW_VAL], pin_a_s); // see R7
    tx_b_nxt  = tx_effective(src_r[`TXPA_BIT_TXSW_SEL],
                             src_r[`TXPA_BIT_TXSW_VAL], pin_b_s); // see R7

    // bits 6..3 of pwrdn_r are dac0..dac3
    pd_nxt[0] = dac_down(pwrdn_r[`TXPA_BIT_PD_DAC0],
                         mask_r[`TXPA_BIT_MASK_A], tx_a_nxt); // see R2 R14
    pd_nxt[1] = dac_down(pwrdn_r[`TXPA_BIT_PD_DAC0 - 1],
                         mask_r[`TXPA_BIT_MASK_A], tx_a_nxt); // see R2 R14
    pd_nxt[2] = dac_down(pwrdn_r[`TXPA_BIT_PD_DAC0 - 2],
                         mask_r[`TXPA_BIT_MASK_B], tx_b_nxt); // see R1 R14
    pd_nxt[3] = dac_down(pwrdn_r[`TXPA_BIT_PD_DAC0 - 3],
                         mask_r[`TXPA_BIT_MASK_B], tx_b_nxt); // see R1 R14

    // the amp is on only when every selected source agrees
    any_src   = src_r[`TXPA_BIT_SRC_PROT] | src_r[`TXPA_BIT_SRC_TXSM]
              | src_r[`TXPA_BIT_SRC_BLSM] | src_r[`TXPA_BIT_SRC_SW];
    // no selected source leaves the amp off
    amp_nxt   = any_src
              & src_vote(src_r[`TXPA_BIT_SRC_PROT], i_amp_protection_ok)   // see R3 R16
              & src_vote(src_r[`TXPA_BIT_SRC_TXSM], i_amp_tx_fsm_on)       // see R4 R16
              & src_vote(src_r[`TXPA_BIT_SRC_BLSM], i_amp_blanking_fsm_on) // see R5 R16
              & src_vote(src_r[`TXPA_BIT_SRC_SW], src_r[`TXPA_BIT_SW_ON]); // see R6 R16

    // events are pulses; there is no sticky status to clear
    irq_nxt   = irq_hit(irqen_r[`TXPA_BIT_IRQ_CUL], i_conv_pll_unlock_ev) // see R10 R15
              | irq_hit(irqen_r[`TXPA_BIT_IRQ_CL], i_conv_pll_lock_ev)    // see R11 R15
              | irq_hit(irqen_r[`TXPA_BIT_IRQ_LUL], i_link_pll_unlock_ev) // see R12 R15
              | irq_hit(irqen_r[`TXPA_BIT_IRQ_LL], i_link_pll_lock_ev);   // see R13 R15
  end

  // signed delay in half dac periods: code 0 is four periods early
  assign dly_half_nxt = {1'b0, dly_r[3:0]} - `TXPA_DLY_OFS_HALF; // see R9

  // read port: one-cycle valid, data held until the next read
  // reads of reserved or unmapped addresses return zero
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 8'h00;
    end else if (i_ce) begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= reg_read(i_addr);
      end
    end
  end

  // power-down outputs
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dac_powerdown <= 4'hf;
      o_ref_powerdown <= 1'b1;
    end else if (i_ce) begin
      o_dac_powerdown <= pd_nxt; // see R1 R2 R14
      o_ref_powerdown <= pwrdn_r[`TXPA_BIT_PD_REF];
    end
  end

  // effective transmit enables
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_tx_enable_a <= 1'b0;
      o_tx_enable_b <= 1'b0;
    end else if (i_ce) begin
      o_tx_enable_a <= tx_a_nxt; // see R7
      o_tx_enable_b <= tx_b_nxt; // see R7
    end
  end

  // registered so that a source mux glitch never reaches the amp pin
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_amp_enable <= 1'b0;
    end else if (i_ce) begin
      o_amp_enable <= amp_nxt; // see R16
    end
  end

  // coarse delay outputs
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_coarse_delay_code <= 4'h8;
      o_coarse_delay_half <= 5'sh00;
    end else if (i_ce) begin
      o_coarse_delay_code <= dly_r[3:0];   // see R8
      o_coarse_delay_half <= dly_half_nxt; // see R9
    end
  end

  // interrupt pulse, one cycle for each cycle holding any enabled event; coinciding events merge
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= irq_nxt; // see R15
    end
  end
endmodule // txpa_regs

// ### src/txpa_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; value changes once stages two and three agree
module txpa_sync (
  // clock and control
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_ce,
  // data
  input  wire i_async,
  output reg  o_sync
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_sync <= s3_r;
      end
    end
  end
endmodule // txpa_sync
